// >>> hdl/rtc_access_pkg.sv
/*
  Package for the serial-bus access engine of the clock/calendar memory.
  Holds the bus control code, the address map of the two storage blocks,
  the link state type, the pin carrier and the pointer step function.
  Assumes the single design module imports it whole.
*/
// Summary of operation
// - Write control byte after Start is acknowledged; an address byte follows.
// - Byte after an acknowledged write control byte loads the pointer, then acknowledged.
// - Single write: one data byte stored and acknowledged, then master sends Stop.
// - Address above 0x5F: no acknowledge of address or data, nothing stored.
// - After a byte write the pointer holds the next location, wrapping in block.
// - Sequential write: each data byte acknowledged, stored in that slot, pointer plus one.
// - No limit on data bytes in one write; only Stop or a repeated Start ends it.
// - Timekeeping block wraps from 0x1F to 0x00, never into memory.
// - Memory block wraps from 0x5F to 0x20, never into timekeeping.
// - Pointer is last accessed location plus one; current read returns next byte.
// - Read control byte is acknowledged, then one byte shifts out from pointer.
// - Master withholds acknowledge and sends Stop; device stops driving data.
// - Repeated Start after address acknowledge keeps the loaded pointer.
// - Read after repeated Start returns addressed byte, pointer left one beyond.
// - Master acknowledge makes device step pointer and send the next byte.
// - One control code reaches both blocks; only its last bit picks direction.
// - Timekeeping registers at 0x00 to 0x1F, memory at 0x20 to 0x5F.
// - No bus access to either block while running from the backup supply; code refuses only the control byte, an accepted frame runs on.
// - Reset leaves memory contents untouched.
package rtc_access_pkg;

  // ****************************************************************
  // Address map and control code
  // ****************************************************************
  localparam int          PTR_W       = 7;
  localparam int          MEM_WORDS   = 96;
  localparam logic [6:0]  CTRL_CODE   = 7'h6F;
  localparam logic [6:0]  TK_BASE     = 7'h00;
  localparam logic [6:0]  TK_TOP      = 7'h1F;
  localparam logic [6:0]  SRAM_BASE   = 7'h20;
  localparam logic [6:0]  SRAM_TOP    = 7'h5F;
  localparam logic [7:0]  ADDR_LIMIT  = 8'h5F;
  localparam logic [3:0]  BYTE_BITS   = 4'h8;
  localparam logic [3:0]  BIT_ZERO    = 4'h0;
  localparam logic [3:0]  BIT_ONE     = 4'h1;
  localparam logic [6:0]  PTR_RESET   = 7'h00;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CTRL,
    ST_ADDR,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } link_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } link_pins_s;

  // ****************************************************************
  // Pointer step with per-block wrap
  // ****************************************************************
  function automatic logic [6:0] next_ptr(input logic [6:0] p);
    logic [6:0] r;
    r = p + 7'h01;
    if (p == TK_TOP) begin
      r = TK_BASE;
    end else if (p == SRAM_TOP) begin
      r = SRAM_BASE;
    end
    return r;
  endfunction

endpackage

// >>> hdl/i2c_rtc_sram_access.sv
/*
  Serial-bus slave access engine for the timekeeping registers and the
  battery-backed memory. Bus pins are oversampled on link_clk; the frame
  state is reported back to the sys_clk side.
  Assumes: the master owns the serial clock and all Start/Stop sequencing,
  link_clk runs fast enough to see every bus edge, and the wire level is
  resolved outside from sda_oe (drive low when high).
*/
`timescale 1ns/1ps
module i2c_rtc_sram_access #(
  parameter int DEPTH = rtc_access_pkg::MEM_WORDS
) (
  input  wire logic                      sys_clk,
  input  wire logic                      srst,
  input  wire logic                      link_clk,
  input  wire logic                      scl_i,
  input  wire logic                      sda_i,
  output logic                           sda_o,
  output logic                           sda_oe,
  input  wire logic                      on_backup,
  output logic                           busy
);
  import rtc_access_pkg::*;

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (DEPTH != int'(SRAM_TOP) + 1) begin : g_depth_check
    $error("DEPTH must cover the whole address map");
  end

  // ****************************************************************
  // Reset and pin synchronisers in the link domain
  // ****************************************************************
  logic        rst_meta_reg;
  logic        link_rst;
  link_pins_s  pins_meta_reg;
  link_pins_s  pins_reg;
  link_pins_s  pins_prev_reg;
  logic        backup_meta_reg;
  logic        backup_reg;

  always_ff @(posedge link_clk) begin
    rst_meta_reg <= srst;
    link_rst     <= rst_meta_reg;
  end

  always_ff @(posedge link_clk) begin
    pins_meta_reg   <= '{scl: scl_i, sda: sda_i};
    pins_reg        <= pins_meta_reg;
    pins_prev_reg   <= pins_reg;
    backup_meta_reg <= on_backup;
    backup_reg      <= backup_meta_reg;
  end

  // ****************************************************************
  // Bus event decode
  // ****************************************************************
  // Decode reads the second and third stages, never the metastable first one
  wire scl_rise  = pins_reg.scl & ~pins_prev_reg.scl;
  wire scl_fall  = ~pins_reg.scl & pins_prev_reg.scl;
  wire start_det = pins_reg.scl & pins_prev_reg.scl & pins_prev_reg.sda & ~pins_reg.sda;
  wire stop_det  = pins_reg.scl & pins_prev_reg.scl & ~pins_prev_reg.sda & pins_reg.sda;

  // ****************************************************************
  // Link state
  // ****************************************************************
  link_state_e state_reg;
  link_state_e state_next;
  logic [3:0]  bitcnt_reg;
  logic        ack_reg;
  logic        mack_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  tx_reg;
  logic [6:0]  ptr_reg;
  logic [6:0]  ptr_next;
  logic        sda_oe_next;
  logic [7:0]  mem [DEPTH];

  wire active    = (state_reg != ST_IDLE) && (state_reg != ST_IGNORE);
  wire rx_state  = (state_reg == ST_CTRL) || (state_reg == ST_ADDR) || (state_reg == ST_WDATA);
  wire byte_done = scl_fall && !ack_reg && (bitcnt_reg == BYTE_BITS) && active;
  wire decide    = byte_done && rx_state;
  wire ack_end   = scl_fall && ack_reg && active;
  wire rx_bit    = scl_rise && !ack_reg && (bitcnt_reg != BYTE_BITS) && active;
  wire tx_shift  = scl_fall && !ack_reg && (state_reg == ST_RDATA)
                   && (bitcnt_reg != BYTE_BITS) && (bitcnt_reg != BIT_ZERO);
  // In the control acknowledge this sees the device's own low, which launches byte one
  wire mack_slot = scl_rise && ack_reg && (state_reg == ST_RDATA);

  // One code for both blocks, last bit picks direction; refused on backup
  wire ctrl_ok   = (shift_reg[7:1] == CTRL_CODE) && !backup_reg;
  wire ctrl_rd   = shift_reg[0];
  wire addr_ok   = (shift_reg <= ADDR_LIMIT);
  wire give_ack  = (state_reg == ST_CTRL) ? ctrl_ok :
                   (state_reg == ST_ADDR) ? addr_ok : 1'b1;
  wire ptr_load  = decide && (state_reg == ST_ADDR) && addr_ok;
  wire mem_we    = decide && (state_reg == ST_WDATA);
  wire load_tx   = ack_end && (state_reg == ST_RDATA) && mack_reg;
  wire inc_en    = mem_we || load_tx;
  wire [7:0] mem_rd = mem[ptr_reg];

  // ****************************************************************
  // Next-state selection
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    if (start_det) begin
      state_next = ST_CTRL;
    end else if (stop_det) begin
      state_next = ST_IDLE;
    end else if (decide) begin
      case (state_reg)
        ST_CTRL: begin
          if (!ctrl_ok) begin
            state_next = ST_IGNORE;
          end else if (ctrl_rd) begin
            state_next = ST_RDATA;
          end else begin
            state_next = ST_ADDR;
          end
        end
        ST_ADDR: begin
          state_next = addr_ok ? ST_WDATA : ST_IGNORE;
        end
        default: begin
          state_next = state_reg;
        end
      endcase
    end else if (ack_end && (state_reg == ST_RDATA) && !mack_reg) begin
      state_next = ST_IGNORE;
    end
  end

  // Pointer: load from address byte, else step with per-block wrap
  assign ptr_next = ptr_load ? shift_reg[6:0] :
                    inc_en   ? next_ptr(ptr_reg) : ptr_reg;

  // Drive is set only after a synced SCL fall; Start and Stop release it while SCL is high
  always_comb begin
    sda_oe_next = sda_oe;
    if (start_det || stop_det) begin
      sda_oe_next = 1'b0;
    end else if (decide) begin
      sda_oe_next = give_ack;
    end else if (byte_done) begin
      sda_oe_next = 1'b0;
    end else if (ack_end) begin
      sda_oe_next = load_tx ? ~mem_rd[7] : 1'b0;
    end else if (tx_shift) begin
      sda_oe_next = ~tx_reg[6];
    end
  end

  // ****************************************************************
  // Link registers
  // ****************************************************************
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      state_reg <= ST_IDLE;
      sda_oe    <= 1'b0;
      sda_o     <= 1'b0;
      ptr_reg   <= PTR_RESET;
    end else begin
      state_reg <= state_next;
      sda_oe    <= sda_oe_next;
      sda_o     <= 1'b0;
      ptr_reg   <= ptr_next;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst || start_det || stop_det) begin
      bitcnt_reg <= BIT_ZERO;
      ack_reg    <= 1'b0;
    end else if (rx_bit) begin
      bitcnt_reg <= bitcnt_reg + BIT_ONE;
    end else if (byte_done) begin
      ack_reg    <= 1'b1;
    end else if (ack_end) begin
      ack_reg    <= 1'b0;
      bitcnt_reg <= BIT_ZERO;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      shift_reg <= 8'h00;
      tx_reg    <= 8'h00;
      mack_reg  <= 1'b0;
    end else begin
      if (rx_bit) begin
        shift_reg <= {shift_reg[6:0], pins_reg.sda};
      end
      if (mack_slot) begin
        mack_reg <= ~pins_reg.sda;
      end
      if (load_tx) begin
        tx_reg <= mem_rd;
      end else if (tx_shift) begin
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  // Storage has no reset so contents survive it
  always_ff @(posedge link_clk) begin
    if (mem_we) begin
      mem[ptr_reg] <= shift_reg;
    end
  end

  // ****************************************************************
  // Frame status back to the system domain
  // ****************************************************************
  logic frame_reg;
  logic busy_meta_reg;

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      frame_reg <= 1'b0;
    end else begin
      frame_reg <= (state_next != ST_IDLE);
    end
  end

  // Level crossing; a short frame may be missed, which only affects status
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busy_meta_reg <= 1'b0;
      busy          <= 1'b0;
    end else begin
      busy_meta_reg <= frame_reg;
      busy          <= busy_meta_reg;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_ctrl_write;
    decide && (state_reg == ST_CTRL) && ctrl_ok && !ctrl_rd;
  endsequence

  sequence s_ctrl_read;
    decide && (state_reg == ST_CTRL) && ctrl_ok && ctrl_rd;
  endsequence

  property p_ctrl_write;
    @(posedge link_clk) disable iff (link_rst)
      s_ctrl_write |=> sda_oe && (state_reg == ST_ADDR);
  endproperty

  property p_ctrl_read;
    @(posedge link_clk) disable iff (link_rst)
      s_ctrl_read |=> sda_oe && (state_reg == ST_RDATA);
  endproperty

  ctrl_write_ack_a: assert property (p_ctrl_write)
    else $error("write control byte not acknowledged");

  ctrl_read_ack_a: assert property (p_ctrl_read)
    else $error("read control byte not acknowledged");

  addr_load_a: assert property (@(posedge link_clk) disable iff (link_rst)
    ptr_load |=> sda_oe && ({1'b0, ptr_reg} == $past(shift_reg)))
    else $error("address byte not loaded into pointer");

  bad_addr_nack_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (decide && (state_reg == ST_ADDR) && !addr_ok)
      |=> !sda_oe && (state_reg == ST_IGNORE) && $stable(ptr_reg))
    else $error("out of range address acknowledged");

  write_step_a: assert property (@(posedge link_clk) disable iff (link_rst)
    mem_we |=> sda_oe && (ptr_reg == next_ptr($past(ptr_reg)))
      && (mem[$past(ptr_reg)] == $past(shift_reg)))
    else $error("data byte not stored or pointer not stepped");

  tk_wrap_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (inc_en && (ptr_reg == TK_TOP)) |=> (ptr_reg == TK_BASE))
    else $error("timekeeping block did not wrap");

  sram_wrap_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (inc_en && (ptr_reg == SRAM_TOP)) |=> (ptr_reg == SRAM_BASE))
    else $error("memory block did not wrap");

  read_step_a: assert property (@(posedge link_clk) disable iff (link_rst)
    load_tx |=> (tx_reg == $past(mem_rd)) && (ptr_reg == next_ptr($past(ptr_reg))))
    else $error("read did not step pointer past byte sent");

  nack_release_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (ack_end && (state_reg == ST_RDATA) && !mack_reg)
      |=> !sda_oe [*2])
    else $error("data still driven after master withheld acknowledge");

  backup_refuse_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (decide && (state_reg == ST_CTRL) && backup_reg)
      |=> !sda_oe && (state_reg == ST_IGNORE))
    else $error("access accepted on backup supply");

  ptr_reset_a: assert property (@(posedge link_clk)
    $past(link_rst) |-> (ptr_reg == PTR_RESET))
    else $error("pointer not cleared by reset");

  // ****************************************************************
  // Transmit path and frame boundaries
  // ****************************************************************
  // Each read bit reaches the pin in the cycle after it is taken from the byte
  sequence s_first_bit;
    load_tx;
  endsequence

  sequence s_later_bit;
    tx_shift;
  endsequence

  first_bit_a: assert property (@(posedge link_clk) disable iff (link_rst)
    s_first_bit |=> (sda_oe == !tx_reg[7]))
    else $error("first read bit not driven from loaded byte");

  later_bit_a: assert property (@(posedge link_clk) disable iff (link_rst)
    s_later_bit |=> (sda_oe == !tx_reg[7]))
    else $error("read bit not driven in order");

  slot_release_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (byte_done && (state_reg == ST_RDATA)) |=> !sda_oe && ack_reg)
    else $error("data line not released for master acknowledge");

  // Repeated Start must not cost the pointer loaded by the cut write
  restart_keep_a: assert property (@(posedge link_clk) disable iff (link_rst)
    start_det |=> (state_reg == ST_CTRL) && $stable(ptr_reg))
    else $error("repeated start disturbed the pointer");

  stop_release_a: assert property (@(posedge link_clk) disable iff (link_rst)
    stop_det |=> !sda_oe && (state_reg == ST_IDLE))
    else $error("data line still driven after stop");

  // A refused frame stays silent until the next Start or Stop
  ignore_quiet_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (state_reg == ST_IGNORE) |-> !sda_oe && !mem_we && !ptr_load)
    else $error("ignored frame touched the bus or storage");

endmodule

// >>> verification/i2c_master_model.sv
/*
  Bus master model for the access engine: owns the serial clock and
  all Start, Stop and acknowledge sequencing.
  Assumes open-drain lines with pull-ups; the data wire is resolved here
  from the model's release and the device's sda_oe.
*/
`timescale 1ns/1ps
module i2c_master_model (
  input  wire logic clk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic sda_rel;

  // ****************************************************************
  // Wire resolution
  // ****************************************************************
  // Pull-up wins only when nobody pulls low
  assign sda = sda_rel & ~sda_oe;

  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // ****************************************************************
  // Bus sequencing
  // ****************************************************************
  // Quarter bit of 4 system cycles keeps the link side well oversampled
  task automatic q();
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic start();
    sda_rel = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_rel = 1'b0;
    q();
    scl = 1'b0;
  endtask

  task automatic stop();
    q();
    sda_rel = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_rel = 1'b1;
    q();
  endtask

  task automatic bit_io(input logic b, output logic s);
    q();
    sda_rel = b;
    q();
    scl = 1'b1;
    q();
    s = sda;
    q();
    scl = 1'b0;
  endtask

  // Sends d MSB first, then mack in the ninth slot (low acknowledges)
  task automatic xfer(input logic [7:0] d, input logic mack,
                      output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(mack, ack);
  endtask
endmodule

// >>> verification/i2c_rtc_sram_access_bench.sv
/*
  Self-checking bench for the access engine: writes, reads, wraps,
  refusals and reset retention, judged against a shadow memory.
  Assumes the master model above and the package constants.
*/
`timescale 1ns/1ps
module i2c_rtc_sram_access_bench;
  import rtc_access_pkg::*;
  logic       sys_clk = 1'b0;
  logic       link_clk = 1'b0;
  logic       srst = 1'b1;
  logic       on_backup = 1'b0;
  logic       scl, sda, sda_o, sda_oe, busy, ack;
  logic [7:0] rd;
  logic [6:0] ptr;
  logic [7:0] shadow [0:95];
  int         failures = 0;
  int         total_checks = 0;

  always #25 sys_clk = ~sys_clk;
  initial begin
    #7;
    forever #16 link_clk = ~link_clk;
  end

  i2c_rtc_sram_access i_i2c_rtc_sram_access (.sys_clk(sys_clk), .srst(srst),
    .link_clk(link_clk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .on_backup(on_backup), .busy(busy));
  i2c_master_model i_i2c_master_model (.clk(sys_clk), .sda_oe(sda_oe),
    .scl(scl), .sda(sda));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic complete_run();
    if (failures == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string m);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, seen, exp);
    end
  endtask

  function automatic logic [6:0] step(input logic [6:0] p);
    return (p == 7'h1F) ? 7'h00 : (p == 7'h5F) ? 7'h20 : p + 7'h01;
  endfunction

  task automatic reset_dut();
    @(posedge sys_clk);
    #1;
    srst = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic send(input logic [7:0] d, input logic exp_ack);
    i_i2c_master_model.xfer(d, 1'b1, rd, ack);
    check({7'h00, ack}, {7'h00, ~exp_ack}, "ack");
  endtask

  task automatic write_seq(input logic [6:0] a, input int n, input logic [7:0] d);
    i_i2c_master_model.start();
    send(8'hDE, 1'b1);
    send({1'b0, a}, 1'b1);
    check({7'h00, busy}, 8'h01, "busy");
    ptr = a;
    for (int i = 0; i < n; i++) begin
      send(d + 8'(i), 1'b1);
      shadow[ptr] = d + 8'(i);
      ptr = step(ptr);
    end
    i_i2c_master_model.stop();
  endtask

  task automatic read_seq(input logic rnd, input logic [6:0] a, input int n);
    i_i2c_master_model.start();
    if (rnd) begin
      send(8'hDE, 1'b1);
      send({1'b0, a}, 1'b1);
      i_i2c_master_model.start();
      ptr = a;
    end
    send(8'hDF, 1'b1);
    for (int i = 0; i < n; i++) begin
      i_i2c_master_model.xfer(8'hFF, i == n - 1, rd, ack);
      check(rd, shadow[ptr], "read data");
      ptr = step(ptr);
    end
    i_i2c_master_model.stop();
    check({7'h00, sda_oe}, 8'h00, "released");
    check({7'h00, sda_o}, 8'h00, "drive level");
    repeat (4) @(posedge sys_clk);
    #1;
    check({7'h00, busy}, 8'h00, "idle");
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Memory must survive reset while the pointer returns to zero
  task automatic t_reset_retain();
    write_seq(7'h00, 1, 8'h3C);
    reset_dut();
    ptr = 7'h00;
    read_seq(1'b0, 7'h00, 1);
  endtask

  task automatic t_wraps();
    write_seq(7'h1E, 4, 8'h10);
    read_seq(1'b1, 7'h1E, 3);
    read_seq(1'b0, 7'h00, 1);
    write_seq(7'h5E, 3, 8'hA0);
    read_seq(1'b1, 7'h5E, 3);
  endtask

  // Refused address must neither store nor move the pointer
  task automatic t_byte_and_bad();
    write_seq(7'h41, 1, 8'h77);
    write_seq(7'h40, 1, 8'h66);
    i_i2c_master_model.start();
    send(8'hDE, 1'b1);
    send(8'h60, 1'b0);
    send(8'h99, 1'b0);
    i_i2c_master_model.stop();
    ptr = 7'h41;
    read_seq(1'b0, 7'h00, 1);
    read_seq(1'b1, 7'h00, 1);
  endtask

  task automatic t_refused();
    on_backup = 1'b1;
    repeat (4) @(posedge sys_clk);
    i_i2c_master_model.start();
    send(8'hDF, 1'b0);
    i_i2c_master_model.stop();
    on_backup = 1'b0;
    i_i2c_master_model.start();
    send(8'hD0, 1'b0);
    i_i2c_master_model.stop();
    read_seq(1'b1, 7'h40, 1);
  endtask

  initial begin
    repeat (50000) @(posedge sys_clk);
    failures++;
    complete_run();
  end

  initial begin
    reset_dut();
    t_reset_retain();
    t_wraps();
    t_byte_and_bad();
    t_refused();
    complete_run();
  end
endmodule
